// *** logic/mcu_alu.sv ***
// eight-bit adder and logic unit of the execute core
// assumes operands are stable for the whole execute phase
`timescale 1ns/1ns
module mcu_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire mcu_exec_pkg::alu_op_t op,
  output logic [7:0] y,
  output logic c,
  output logic ac,
  output logic ov
);
  import mcu_exec_pkg::*;
  logic [7:0] bb;
  logic ci;
  logic [4:0] lo;
  logic [8:0] sum;

  // subtraction is a plus not b plus one, so carry set means no borrow
  always_comb begin
    bb = b;
    ci = 1'b0;
    case (op)
      ALU_ADC: ci = cin;
      ALU_SUB: begin
        bb = ~b;
        ci = 1'b1;
      end
      ALU_SBC: begin
        bb = ~b;
        ci = cin;
      end
      default: ci = 1'b0;
    endcase
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    case (op)
      ALU_AND: y = a & b;
      ALU_OR: y = a | b;
      ALU_XOR: y = a ^ b;
      default: y = sum[7:0];
    endcase
    c = sum[8];
    ac = lo[4];
    ov = (a[7] == bb[7]) && (sum[7] != a[7]);
  end
endmodule

// *** logic/mcu_exec_pkg.sv ***
// constants and types shared by the instruction execute core
// assumes a single 20 MHz system clock and 16-bit program words
package mcu_exec_pkg;
  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  // one instruction cycle is four system clocks
  localparam int CLKS_PER_CYCLE = 4;
  localparam logic [1:0] PH_FETCH = 2'h1;
  localparam logic [1:0] PH_LAST = 2'(CLKS_PER_CYCLE - 1);
  localparam logic [1:0] EXTRA_ONE = 2'h1;

  // ************************************************************
  // status bit positions and reset value
  // ************************************************************
  localparam int F_CARRY = 0;
  localparam int F_AUXC = 1;
  localparam int F_OVF = 2;
  localparam int F_ZERO = 3;
  localparam int F_PWDN = 4;
  localparam int F_TOUT = 5;
  localparam logic [5:0] STATUS_RST = 6'h00;

  // ************************************************************
  // special register addresses and table page
  // ************************************************************
  localparam logic [7:0] PCLOW_ADDR = 8'h06;
  localparam logic [7:0] TABLO_ADDR = 8'h07;
  localparam logic [7:0] TABRES_ADDR = 8'h08;
  localparam logic [7:0] TABHI_ADDR = 8'h1f;
  localparam logic [4:0] LAST_PAGE = 5'h1f;

  // ************************************************************
  // instruction classes in word bits 15..13
  // ************************************************************
  localparam logic [2:0] CLS_CALL = 3'h7;
  localparam logic [2:0] CLS_JMP = 3'h6;
  localparam logic [2:0] CLS_BIT = 3'h5;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDM, OP_ADDI, OP_ADC, OP_ADCM, OP_SUB,
    OP_SUBM, OP_SUBI, OP_SBC, OP_SBCM, OP_DECADJ, OP_AND, OP_OR,
    OP_XOR, OP_ANDM, OP_ORM, OP_XORM, OP_ANDI, OP_ORI, OP_XORI,
    OP_CPL, OP_CPLA, OP_INC, OP_INCA, OP_DEC, OP_DECA, OP_RR,
    OP_RRA, OP_RRC, OP_RRCA, OP_RL, OP_RLA, OP_RLC, OP_RLCA,
    OP_MOVA, OP_MOVM, OP_MOVI, OP_SZ, OP_SKZMOV, OP_SKINC,
    OP_SKDEC, OP_SKINCA, OP_SKDECA, OP_RET, OP_RETA, OP_RETI,
    OP_TBLCUR, OP_TBLLAST, OP_CLR, OP_SET, OP_CLRWDT, OP_WDPRE1,
    OP_WDPRE2, OP_SWAP, OP_SWAPA, OP_HALT, OP_CLRB, OP_SETB,
    OP_SZB, OP_SNZB, OP_JMP, OP_CALL
  } op_t;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR
  } alu_op_t;
endpackage

// *** logic/mcu_instruction_execute.sv ***
// instruction decode and execute core of an 8-bit accumulator machine
// assumes program and data memories answer one clock after the address
`timescale 1ns/1ns
module mcu_instruction_execute (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] prog_data,
  input wire logic [7:0] data_rdata,
  input wire logic table_high_opt,
  input wire logic wdt_two_opt,
  input wire logic wdt_timeout,
  input wire logic wake,
  output logic [mcu_exec_pkg::PC_W-1:0] prog_addr,
  output logic [7:0] data_addr,
  output logic [7:0] data_wdata,
  output logic data_we,
  output logic [7:0] accumulator,
  output logic [5:0] status,
  output logic [7:0] table_pointer_low,
  output logic [4:0] table_pointer_high,
  output logic [7:0] table_result_high,
  output logic halted,
  output logic wdt_clear,
  output logic instr_done
);
  import mcu_exec_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] ph;
    logic [PC_W-1:0] pc;
    logic [15:0] ir;
    logic [7:0] acc;
    logic [5:0] st;
    logic [7:0] tlo;
    logic [4:0] thi;
    logic [7:0] tres;
    logic [1:0] extra;
    logic tpend;
    logic halted;
    logic pre1;
    logic pre2;
    logic [PC_W-1:0] paddr;
    logic [7:0] daddr;
    logic [7:0] wdata;
    logic we;
    logic wclr;
    logic done;
    logic [1:0] opt_s1;
    logic [1:0] opt_s2;
  } core_t;
  core_t q;
  core_t d;

  function automatic op_t dec(input logic [15:0] w);
    case (w[15:13])
      CLS_CALL: return OP_CALL;
      CLS_JMP: return OP_JMP;
      CLS_BIT: return op_t'(6'(OP_CLRB) + {4'h0, w[12:11]});
      default: return op_t'(w[13:8]);
    endcase
  endfunction

  function automatic logic mem_dest(input op_t o);
    return o inside {OP_ADDM, OP_ADCM, OP_SUBM, OP_SBCM, OP_DECADJ,
      OP_ANDM, OP_ORM, OP_XORM, OP_CPL, OP_INC, OP_DEC, OP_RR,
      OP_RRC, OP_RL, OP_RLC, OP_MOVM, OP_CLRB, OP_SETB, OP_SKINC,
      OP_SKDEC, OP_SWAP, OP_CLR, OP_SET};
  endfunction

  function automatic logic acc_dest(input op_t o);
    return o inside {OP_ADD, OP_ADDI, OP_ADC, OP_SUB, OP_SUBI,
      OP_SBC, OP_AND, OP_OR, OP_XOR, OP_ANDI, OP_ORI, OP_XORI,
      OP_CPLA, OP_INCA, OP_DECA, OP_RRA, OP_RRCA, OP_RLA, OP_RLCA,
      OP_MOVA, OP_MOVI, OP_SKZMOV, OP_SKINCA, OP_SKDECA, OP_RETA,
      OP_SWAPA};
  endfunction

  op_t op;
  logic [7:0] m;
  logic [7:0] rd;
  logic [2:0] bi;
  logic [PC_W-1:0] pc1;
  logic [PC_W-1:0] pc_n;
  logic [PC_W-1:0] top;
  logic push;
  logic pop;
  alu_op_t alu_sel;
  logic [7:0] alu_b;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_ac;
  logic alu_ov;
  logic [4:0] lo5;
  logic [4:0] hi5;
  logic [7:0] daa_v;
  logic daa_c;
  logic [7:0] val;
  logic [1:0] ext;
  logic fz;
  logic fa;
  logic wr;
  logic skip;
  logic wd_hit;
  logic wd_first;

  assign op = dec(q.ir);
  assign m = q.ir[7:0];
  assign bi = q.ir[10:8];
  assign pc1 = q.pc + 13'h0001;

  // core-held special registers answer reads instead of the memory
  always_comb begin
    case (q.daddr)
      PCLOW_ADDR: rd = q.pc[7:0];
      TABLO_ADDR: rd = q.tlo;
      TABHI_ADDR: rd = {3'h0, q.thi};
      TABRES_ADDR: rd = q.tres;
      default: rd = data_rdata;
    endcase
  end

  // ************************************************************
  // operand steering and decimal adjust
  // ************************************************************
  always_comb begin
    alu_b = op inside {OP_ADDI, OP_SUBI, OP_ANDI, OP_ORI, OP_XORI} ?
      q.ir[7:0] : rd;
    case (op)
      OP_ADC, OP_ADCM: alu_sel = ALU_ADC;
      OP_SUB, OP_SUBI, OP_SUBM: alu_sel = ALU_SUB;
      OP_SBC, OP_SBCM: alu_sel = ALU_SBC;
      OP_AND, OP_ANDI, OP_ANDM: alu_sel = ALU_AND;
      OP_OR, OP_ORI, OP_ORM: alu_sel = ALU_OR;
      OP_XOR, OP_XORI, OP_XORM: alu_sel = ALU_XOR;
      default: alu_sel = ALU_ADD;
    endcase
    lo5 = {1'b0, q.acc[3:0]};
    if (q.acc[3:0] > 4'h9 || q.st[F_AUXC]) begin
      lo5 = lo5 + 5'h06;
    end
    hi5 = {1'b0, q.acc[7:4]} + {4'h0, lo5[4]};
    daa_c = q.st[F_CARRY];
    if (hi5 > 5'h09 || q.st[F_CARRY]) begin
      hi5 = hi5 + 5'h06;
      daa_c = 1'b1;
    end
    daa_v = {hi5[3:0], lo5[3:0]};
  end

  mcu_alu alu_u (
    .a(q.acc),
    .b(alu_b),
    .cin(q.st[F_CARRY]),
    .op(alu_sel),
    .y(alu_y),
    .c(alu_c),
    .ac(alu_ac),
    .ov(alu_ov)
  );

  mcu_stack stack_u (
    .clk(clk),
    .rst_n(rst_n),
    .push(push),
    .pop(pop),
    .din(pc1),
    .top(top)
  );

  // ************************************************************
  // sequencing and execute
  // ************************************************************
  always_comb begin
    d = q;
    d.opt_s1 = {table_high_opt, wdt_two_opt};
    d.opt_s2 = q.opt_s1;
    d.ph = q.ph + 2'h1;
    d.we = 1'b0;
    d.wclr = 1'b0;
    d.done = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    val = rd;
    ext = 2'h0;
    fz = 1'b0;
    fa = 1'b0;
    wr = 1'b0;
    skip = 1'b0;
    wd_hit = 1'b0;
    wd_first = 1'b0;
    pc_n = pc1;
    if (q.halted) begin
      // clock is stopped: no phase advance until woken
      d.ph = 2'h0;
      d.halted = !wake;
    end else if (q.ph == PH_FETCH && q.extra == 2'h0) begin
      d.ir = prog_data;
      d.daddr = prog_data[7:0];
    end else if (q.ph == PH_LAST && q.extra != 2'h0) begin
      d.extra = q.extra - 2'h1;
      if (q.tpend) begin
        d.tres = prog_data[15:8];
        d.wdata = prog_data[7:0];
        d.we = 1'b1;
        d.tpend = 1'b0;
        d.paddr = q.pc;
      end
    end else if (q.ph == PH_LAST) begin
      case (op)
        OP_ADD, OP_ADDI, OP_ADC, OP_SUB, OP_SUBI, OP_SBC, OP_ADDM,
        OP_ADCM, OP_SUBM, OP_SBCM: begin
          val = alu_y;
          fz = 1'b1;
          fa = 1'b1;
        end
        OP_AND, OP_OR, OP_XOR, OP_ANDI, OP_ORI, OP_XORI, OP_ANDM,
        OP_ORM, OP_XORM: begin
          val = alu_y;
          fz = 1'b1;
        end
        OP_CPL, OP_CPLA: begin
          val = ~rd;
          fz = 1'b1;
        end
        OP_INC, OP_INCA: begin
          val = rd + 8'h01;
          fz = 1'b1;
        end
        OP_DEC, OP_DECA: begin
          val = rd - 8'h01;
          fz = 1'b1;
        end
        OP_DECADJ: begin
          val = daa_v;
          d.st[F_CARRY] = daa_c;
        end
        OP_RR, OP_RRA: val = {rd[0], rd[7:1]};
        OP_RL, OP_RLA: val = {rd[6:0], rd[7]};
        OP_RRC, OP_RRCA: begin
          val = {q.st[F_CARRY], rd[7:1]};
          d.st[F_CARRY] = rd[0];
        end
        OP_RLC, OP_RLCA: begin
          val = {rd[6:0], q.st[F_CARRY]};
          d.st[F_CARRY] = rd[7];
        end
        OP_MOVA: val = rd;
        OP_MOVM: val = q.acc;
        OP_MOVI: val = q.ir[7:0];
        OP_SWAP, OP_SWAPA: val = {rd[3:0], rd[7:4]};
        OP_CLR: val = 8'h00;
        OP_SET: val = 8'hff;
        OP_CLRB: val = rd & ~(8'h01 << bi);
        OP_SETB: val = rd | (8'h01 << bi);
        OP_SZ: skip = (rd == 8'h00);
        OP_SKZMOV: skip = (rd == 8'h00);
        OP_SZB: skip = !rd[bi];
        OP_SNZB: skip = rd[bi];
        OP_SKINC, OP_SKINCA: begin
          val = rd + 8'h01;
          skip = (val == 8'h00);
        end
        OP_SKDEC, OP_SKDECA: begin
          val = rd - 8'h01;
          skip = (val == 8'h00);
        end
        OP_JMP: begin
          pc_n = q.ir[PC_W-1:0];
          ext = EXTRA_ONE;
        end
        OP_CALL: begin
          push = 1'b1;
          pc_n = q.ir[PC_W-1:0];
          ext = EXTRA_ONE;
        end
        OP_RET, OP_RETI, OP_RETA: begin
          pop = 1'b1;
          pc_n = top;
          val = q.ir[7:0];
          ext = EXTRA_ONE;
        end
        OP_TBLCUR, OP_TBLLAST: begin
          d.tpend = 1'b1;
          ext = EXTRA_ONE;
        end
        OP_CLRWDT: begin
          d.wclr = 1'b1;
          d.st[F_PWDN] = 1'b0;
          d.st[F_TOUT] = 1'b0;
          d.pre1 = 1'b0;
          d.pre2 = 1'b0;
        end
        OP_WDPRE1, OP_WDPRE2: begin
          // with the two-preclear option on, repeating one preclear alone never clears the watchdog
          wd_first = (op == OP_WDPRE1);
          wd_hit = !q.opt_s2[0] || (wd_first ? q.pre2 : q.pre1);
          if (wd_hit) begin
            d.wclr = 1'b1;
            d.st[F_PWDN] = 1'b0;
            d.st[F_TOUT] = 1'b0;
            d.pre1 = 1'b0;
            d.pre2 = 1'b0;
          end else if (wd_first) begin
            d.pre1 = 1'b1;
          end else begin
            d.pre2 = 1'b1;
          end
        end
        OP_HALT: begin
          d.halted = 1'b1;
          d.wclr = 1'b1;
          d.st[F_PWDN] = 1'b1;
          d.st[F_TOUT] = 1'b0;
        end
        default: val = rd;
      endcase
      wr = mem_dest(op);
      if (fz) begin
        d.st[F_ZERO] = (val == 8'h00);
      end
      if (fa) begin
        d.st[F_CARRY] = alu_c;
        d.st[F_AUXC] = alu_ac;
        d.st[F_OVF] = alu_ov;
      end
      if (acc_dest(op)) begin
        d.acc = val;
      end
      if (skip) begin
        pc_n = q.pc + 13'h0002;
        ext = ext + EXTRA_ONE;
      end
      if (wr && m == PCLOW_ADDR) begin
        pc_n = {pc1[PC_W-1:8], val};
        ext = ext + EXTRA_ONE;
      end
      if (wr && m == TABLO_ADDR) begin
        d.tlo = val;
      end
      if (wr && m == TABHI_ADDR) begin
        d.thi = val[4:0];
      end
      d.pc = pc_n;
      d.extra = ext;
      d.wdata = val;
      d.we = wr;
      d.done = 1'b1;
      d.paddr = pc_n;
      if (op == OP_TBLLAST) begin
        d.paddr = {LAST_PAGE, q.tlo};
      end else if (op == OP_TBLCUR) begin
        d.paddr = q.opt_s2[1] ? {q.thi, q.tlo} : {q.pc[12:8], q.tlo};
      end
    end
    // a timeout in the cycle of a clear still gets recorded
    if (wdt_timeout) begin
      d.st[F_TOUT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prog_addr = q.paddr;
  assign data_addr = q.daddr;
  assign data_wdata = q.wdata;
  assign data_we = q.we;
  assign accumulator = q.acc;
  assign status = q.st;
  assign table_pointer_low = q.tlo;
  assign table_pointer_high = q.thi;
  assign table_result_high = q.tres;
  assign halted = q.halted;
  assign wdt_clear = q.wclr;
  assign instr_done = q.done;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ex;
  assign ex = (q.ph == PH_LAST) && (q.extra == 2'h0) && !q.halted;

  add_zero_a: assert property (ex && op == OP_ADDI |=>
    q.st[F_ZERO] == (q.acc == 8'h00)) else $error("add zero flag");
  adc_sum_a: assert property (ex && op == OP_ADC |=>
    q.acc == 8'($past(q.acc) + $past(rd) + 8'($past(q.st[F_CARRY]))))
    else $error("adc sum wrong");
  adcm_write_a: assert property (ex && op == OP_ADCM |=>
    q.we && $stable(q.acc)) else $error("adcm no write");
  logic_flags_a: assert property (ex &&
    op inside {OP_ANDI, OP_ANDM, OP_XORI} |=>
    q.st[F_OVF:F_CARRY] == $past(q.st[F_OVF:F_CARRY]))
    else $error("logic op moved flags");
  andi_result_a: assert property (ex && op == OP_ANDI |=>
    q.acc == ($past(q.acc) & $past(q.ir[7:0])))
    else $error("andi result");
  andm_store_a: assert property (ex && op == OP_ANDM |=>
    q.we && q.wdata == ($past(q.acc) & $past(rd)) && $stable(q.acc))
    else $error("andm store");
  rotate_flags_a: assert property (ex &&
    op inside {OP_RL, OP_RLA} |=>
    q.st[F_ZERO:F_CARRY] == $past(q.st[F_ZERO:F_CARRY]))
    else $error("rotate changed flags");
  jump_length_a: assert property (ex && op == OP_JMP |=>
    !ex [*7] ##1 ex) else $error("jump not two cycles");
  call_target_a: assert property (ex && op == OP_CALL |=>
    q.pc == $past(q.ir[PC_W-1:0])) else $error("call target");
  pcl_stretch_a: assert property (ex && mem_dest(op) &&
    m == PCLOW_ADDR |=> q.extra != 2'h0) else $error("no pcl stretch");
  skip_taken_a: assert property (ex && rd == 8'h00 &&
    op inside {OP_SZ, OP_SKZMOV} |=>
    q.pc == 13'($past(q.pc) + 13'h0002) && q.extra != 0)
    else $error("skip not taken");
  halt_entry_a: assert property (ex && op == OP_HALT |=>
    q.halted && q.st[F_PWDN] && q.wclr) else $error("halt entry");
  wdt_clear_a: assert property (ex && op == OP_CLRWDT |=>
    q.wclr && !q.st[F_PWDN]) else $error("watchdog clear");
endmodule

// *** logic/mcu_stack.sv ***
// return address stack of eight levels
// assumes push and pop are never asserted together
`timescale 1ns/1ns
module mcu_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [mcu_exec_pkg::PC_W-1:0] din,
  output logic [mcu_exec_pkg::PC_W-1:0] top
);
  import mcu_exec_pkg::*;
  typedef struct packed {
    logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
    logic [SP_W-1:0] sp;
  } stk_t;
  stk_t q;
  stk_t d;

  // a ninth push wraps and overwrites the oldest entry
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.sp] = din;
      d.sp = q.sp + 3'h1;
    end else if (pop) begin
      d.sp = q.sp - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign top = q.mem[q.sp - 3'h1];
endmodule

// *** verification/mcu_instruction_execute_tb_top.sv ***
// bench top: loads a program, runs the core, checks every result
// assumes the memory model holds the program and the data bytes
`timescale 1ns/1ns
module mcu_instruction_execute_tb_top;
  import mcu_exec_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic table_high_opt = 1'b1;
  logic wdt_two_opt = 1'b1;
  logic wdt_timeout = 1'b0;
  logic wake = 1'b0;
  logic [15:0] prog_data;
  logic [7:0] data_rdata, data_addr, data_wdata, accumulator;
  logic [PC_W-1:0] prog_addr;
  logic [5:0] status;
  logic [7:0] table_pointer_low, table_result_high;
  logic [4:0] table_pointer_high;
  logic data_we, halted, wdt_clear, instr_done;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0, last = 0, n_clr = 0, n_done = 0, pa = 0, p1 = 0, p2 = 0, p3 = 0;
  logic [7:0] ea_q[$];
  logic [5:0] es_q[$];
  int n_q[$];

  always #25 clk = ~clk;

  mcu_instruction_execute mcu_instruction_execute_i (
    .clk(clk), .rst_n(rst_n), .prog_data(prog_data),
    .data_rdata(data_rdata), .table_high_opt(table_high_opt),
    .wdt_two_opt(wdt_two_opt), .wdt_timeout(wdt_timeout), .wake(wake),
    .prog_addr(prog_addr), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we),
    .accumulator(accumulator), .status(status),
    .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high),
    .table_result_high(table_result_high), .halted(halted),
    .wdt_clear(wdt_clear), .instr_done(instr_done)
  );

  mcu_mem_model mcu_mem_model_i (
    .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_wdata(data_wdata),
    .data_we(data_we), .data_rdata(data_rdata)
  );

  // ************************************************************
  // cycle count, pulse counters and hang limit
  // ************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1) begin
      n_clr <= n_clr + 1;
    end
    if (instr_done === 1'b1) begin
      n_done <= n_done + 1;
    end
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  function automatic logic [15:0] op(input op_t o, input logic [7:0] v);
    return {2'b00, o, v};
  endfunction

  // places a word at the load pointer and queues what it must yield
  task automatic ins(input logic [15:0] w, input logic [7:0] ea,
                     input logic [5:0] es, input int n);
    mcu_mem_model_i.rom[pa] = w;
    pa++;
    ea_q.push_back(ea);
    es_q.push_back(es);
    n_q.push_back(n);
  endtask

  // waits for one completion; a length of zero skips its cycle count
  task automatic step(input int k);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (instr_done !== 1'b1 && t < 40);
    check(16'(t < 40), 16'h0001);
    check(16'(accumulator), 16'(ea_q[k]));
    check(16'(status), 16'(es_q[k]));
    // done fires before any dummy cycle, so the gap is the previous length
    if (k > 0 && n_q[k-1] > 0) begin
      check(16'(cyc - last), 16'(4 * n_q[k-1]));
    end
    last = cyc;
    @(negedge clk);
  endtask

  task automatic pulse_timeout();
    wdt_timeout = 1'b1;
    @(negedge clk);
    wdt_timeout = 1'b0;
  endtask

  // ************************************************************
  // program, run and final checks
  // ************************************************************
  initial begin
    for (int a = 0; a < 2**PC_W; a++) begin
      mcu_mem_model_i.rom[a] = 16'h0000;
    end
    for (int a = 0; a < 256; a++) begin
      mcu_mem_model_i.ram[a] = 8'h00;
    end
    mcu_mem_model_i.ram[8'h20] = 8'h10;
    mcu_mem_model_i.ram[8'h21] = 8'hef;
    mcu_mem_model_i.ram[8'h22] = 8'hf0;
    mcu_mem_model_i.ram[8'h23] = 8'h81;
    mcu_mem_model_i.ram[8'h24] = 8'hff;
    mcu_mem_model_i.ram[8'h27] = 8'hff;
    mcu_mem_model_i.ram[8'h28] = 8'h55;
    mcu_mem_model_i.rom[13'h0312] = 16'habcd;
    mcu_mem_model_i.rom[13'h1f12] = 16'h1234;
    ins(op(OP_MOVI, 8'h7f), 8'h7f, 6'h00, 1);
    ins(op(OP_ADDI, 8'h01), 8'h80, 6'h06, 1);
    ins(op(OP_ADDI, 8'h80), 8'h00, 6'h0d, 1);
    ins(op(OP_ADC, 8'h20), 8'h11, 6'h00, 1);
    ins(op(OP_ADCM, 8'h21), 8'h11, 6'h0b, 1);
    ins(op(OP_ANDI, 8'h0f), 8'h01, 6'h03, 1);
    ins(op(OP_ANDM, 8'h22), 8'h01, 6'h0b, 1);
    ins(op(OP_SUBI, 8'h02), 8'hff, 6'h00, 1);
    ins(op(OP_RLC, 8'h23), 8'hff, 6'h01, 1);
    ins(op(OP_RLA, 8'h23), 8'h04, 6'h01, 1);
    ins(op(OP_INCA, 8'h24), 8'h00, 6'h09, 1);
    ins(op(OP_MOVI, 8'ha5), 8'ha5, 6'h09, 1);
    ins(op(OP_ADDI, 8'h00), 8'ha5, 6'h00, 1);
    ins(op(OP_DECADJ, 8'h25), 8'ha5, 6'h01, 1);
    ins({3'h5, 2'h1, 3'h7, 8'h26}, 8'ha5, 6'h01, 1);
    ins({3'h5, 2'h0, 3'h0, 8'h27}, 8'ha5, 6'h01, 1);
    ins(op(OP_SWAPA, 8'h25), 8'h50, 6'h01, 1);
    ins(op(OP_CLR, 8'h28), 8'h50, 6'h01, 1);
    ins(op(OP_SKZMOV, 8'h28), 8'h00, 6'h01, 2);
    mcu_mem_model_i.rom[pa] = op(OP_MOVI, 8'hee);
    pa++;
    ins(op(OP_SZ, 8'h27), 8'h00, 6'h01, 1);
    ins({3'h7, 13'h0040}, 8'h00, 6'h01, 2);
    pa = 'h40;
    ins(op(OP_RETA, 8'h33), 8'h33, 6'h01, 2);
    pa = 22;
    ins({3'h6, 13'h0050}, 8'h33, 6'h01, 2);
    pa = 'h50;
    ins(op(OP_MOVI, 8'h12), 8'h12, 6'h01, 1);
    ins(op(OP_MOVM, 8'h07), 8'h12, 6'h01, 1);
    ins(op(OP_MOVI, 8'h03), 8'h03, 6'h01, 1);
    ins(op(OP_MOVM, 8'h1f), 8'h03, 6'h01, 1);
    ins(op(OP_TBLCUR, 8'h29), 8'h03, 6'h01, 2);
    ins(op(OP_TBLLAST, 8'h2a), 8'h03, 6'h01, 2);
    ins(op(OP_MOVI, 8'h60), 8'h60, 6'h01, 1);
    ins(op(OP_MOVM, 8'h06), 8'h60, 6'h01, 2);
    p1 = n_q.size() - 1;
    pa = 'h60;
    ins(op(OP_NOP, 8'h00), 8'h60, 6'h21, 1);
    ins(op(OP_CLRWDT, 8'h00), 8'h60, 6'h01, 1);
    p2 = n_q.size() - 1;
    ins(op(OP_WDPRE1, 8'h00), 8'h60, 6'h21, 1);
    ins(op(OP_WDPRE2, 8'h00), 8'h60, 6'h01, 1);
    ins(op(OP_HALT, 8'h00), 8'h60, 6'h11, 0);
    p3 = n_q.size();
    ins(op(OP_MOVI, 8'h99), 8'h99, 6'h11, 1);
    // with the option off the page comes from pc: word 8'h12 is program
    ins(op(OP_TBLCUR, 8'h2b), 8'h99, 6'h11, 2);
    ins(op(OP_WDPRE1, 8'h00), 8'h99, 6'h01, 1);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < p3; k++) begin
      step(k);
      if (k == p1 || k == p2) begin
        pulse_timeout();
      end
    end
    p1 = n_done;
    repeat (20) @(negedge clk);
    check(16'(halted), 16'h0001);
    check(16'(n_done), 16'(p1));
    check(16'(n_clr), 16'h0003);
    check(16'(table_result_high), 16'h0012);
    // both options off from here on: a single preclear must clear
    table_high_opt = 1'b0;
    wdt_two_opt = 1'b0;
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    for (int k = p3; k < n_q.size(); k++) begin
      step(k);
    end
    check(16'(n_clr), 16'h0004);
    check(16'(mcu_mem_model_i.ram[8'h2b]), 16'h0028);
    check(16'(mcu_mem_model_i.ram[8'h21]), 16'h0000);
    check(16'(mcu_mem_model_i.ram[8'h22]), 16'h0000);
    check(16'(mcu_mem_model_i.ram[8'h23]), 16'h0002);
    check(16'(mcu_mem_model_i.ram[8'h25]), 16'h0005);
    check(16'(mcu_mem_model_i.ram[8'h26]), 16'h0080);
    check(16'(mcu_mem_model_i.ram[8'h27]), 16'h00fe);
    check(16'(mcu_mem_model_i.ram[8'h28]), 16'h0000);
    check(16'(mcu_mem_model_i.ram[8'h29]), 16'h00cd);
    check(16'(mcu_mem_model_i.ram[8'h2a]), 16'h0034);
    check(16'(table_result_high), 16'h0027);
    check(16'(table_pointer_low), 16'h0012);
    check(16'(table_pointer_high), 16'h0003);
    give_verdict();
  end
endmodule

// *** verification/mcu_mem_model.sv ***
// program and data memory model facing the execute core
// assumes reads answer one clock after the address, writes on data_we
`timescale 1ns/1ns
module mcu_mem_model (
  input wire logic clk,
  input wire logic [mcu_exec_pkg::PC_W-1:0] prog_addr,
  output logic [15:0] prog_data,
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  output logic [7:0] data_rdata
);
  import mcu_exec_pkg::*;
  // ************************************************************
  // storage, loaded by the bench before reset is released
  // ************************************************************
  logic [15:0] rom [2**PC_W];
  logic [7:0] ram [256];

  initial begin
    prog_data = 16'h0000;
    data_rdata = 8'h00;
  end

  // read before write: a byte written this edge shows one clock later
  always @(posedge clk) begin
    prog_data <= rom[prog_addr];
    data_rdata <= ram[data_addr];
    if (data_we === 1'b1) begin
      ram[data_addr] <= data_wdata;
    end
  end
endmodule
